// File: include/amrw_defines.svh
// constants for the memory slave read path and write response
`ifndef AMRW_DEFINES_SVH
`define AMRW_DEFINES_SVH

`define AMRW_ADDR_W    32
`define AMRW_DATA_W    32
`define AMRW_ID_W      4
`define AMRW_LEN_W     8
`define AMRW_SIZE_W    3
`define AMRW_RESP_OKAY 2'h0
`define AMRW_BURST_INC 2'h1
`define AMRW_BURST_WRP 2'h2
`define AMRW_SIZE_FULL 3'h2
`define AMRW_ST_RESET  4'h1

`endif

// File: include/amrw_pkg.sv
// types shared by the memory slave read path
`default_nettype none
`include "amrw_defines.svh"

package amrw_pkg;

	// read engine states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_FETCH = 4'h2,
		ST_CAP   = 4'h4,
		ST_BEAT  = 4'h8
	} amrw_state_t;

	// accepted read command
	typedef struct packed {
		logic [`AMRW_ID_W-1:0]   id;
		logic [`AMRW_LEN_W-1:0]  len;
		logic [`AMRW_SIZE_W-1:0] size;
		logic [1:0]              burst;
	} amrw_cmd_t;

endpackage : amrw_pkg

`default_nettype wire

// File: design/amrw_slave.sv
// read address, read data and write response channels in front of a block memory
`timescale 1ns/100ps
`default_nettype none
`include "amrw_defines.svh"

module amrw_slave (
	input  wire logic                     CLK,           // bus clock, 25 MHz
	input  wire logic                     RESET_N,       // async reset, active low
	input  wire logic                     MEM_MODE,      // 1 memory mode, 0 register mode
	input  wire logic                     ID_EN,         // IDs enabled in memory mode
	input  wire logic [`AMRW_ID_W-1:0]    S_AXI_ARID,    // read address ID
	input  wire logic [`AMRW_ADDR_W-1:0]  S_AXI_ARADDR,  // burst start address
	input  wire logic [`AMRW_LEN_W-1:0]   S_AXI_ARLEN,   // beats minus one
	input  wire logic [`AMRW_SIZE_W-1:0]  S_AXI_ARSIZE,  // log2 bytes per beat
	input  wire logic [1:0]               S_AXI_ARBURST, // burst type
	input  wire logic                     S_AXI_ARVALID, // read address valid
	output logic                          S_AXI_ARREADY, // read address ready
	output logic [`AMRW_ID_W-1:0]         S_AXI_RID,     // read ID echo
	output logic [`AMRW_DATA_W-1:0]       S_AXI_RDATA,   // read data
	output logic [1:0]                    S_AXI_RRESP,   // read response
	output logic                          S_AXI_RLAST,   // final beat
	output logic                          S_AXI_RVALID,  // read data valid
	input  wire logic                     S_AXI_RREADY,  // master takes data
	input  wire logic                     WR_DONE,       // write finished, pulse
	input  wire logic [`AMRW_ID_W-1:0]    WR_ID,         // ID of finished write
	output logic                          WR_DONE_RDY,   // response slot free
	output logic [`AMRW_ID_W-1:0]         S_AXI_BID,     // write response ID
	output logic [1:0]                    S_AXI_BRESP,   // write response code
	output logic                          S_AXI_BVALID,  // write response valid
	input  wire logic                     S_AXI_BREADY,  // master takes response
	output logic                          MEM_REN,       // memory read strobe
	output logic [`AMRW_ADDR_W-1:0]       MEM_ADDR,      // memory byte address
	input  wire logic [`AMRW_DATA_W-1:0]  MEM_RDATA      // data, one cycle after strobe
);

	// ----------------------------------------------------------------
	// address arithmetic
	// ----------------------------------------------------------------

	// bytes in one beat of the given size
	function automatic logic [`AMRW_ADDR_W-1:0] beat_bytes(
		input logic [`AMRW_SIZE_W-1:0] size
	);
		beat_bytes = 32'h1 << size;
	endfunction : beat_bytes

	// bytes covered by the whole burst, the span a wrapping burst stays in
	function automatic logic [`AMRW_ADDR_W-1:0] wrap_region(
		input amrw_pkg::amrw_cmd_t c
	);
		wrap_region = beat_bytes(c.size) * ({24'h0, c.len} + 32'h1);
	endfunction : wrap_region

	// address of the next beat of a burst
	function automatic logic [`AMRW_ADDR_W-1:0] next_addr(
		input logic [`AMRW_ADDR_W-1:0] a,
		input amrw_pkg::amrw_cmd_t     c
	);
		logic [`AMRW_ADDR_W-1:0] b;
		logic [`AMRW_ADDR_W-1:0] inc;
		logic [`AMRW_ADDR_W-1:0] msk;
		b   = beat_bytes(c.size);
		inc = (a & ~(b - 32'h1)) + b;
		msk = wrap_region(c) - 32'h1;
		if (c.burst == `AMRW_BURST_WRP) begin
			next_addr = (a & ~msk) | (inc & msk);
		end else begin
			next_addr = inc;
		end
	endfunction : next_addr

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------

	amrw_pkg::amrw_state_t   state_r;
	amrw_pkg::amrw_state_t   state_nxt;
	amrw_pkg::amrw_cmd_t     cmd_r;
	amrw_pkg::amrw_cmd_t     cmd_nxt;
	logic [`AMRW_ADDR_W-1:0] addr_r;
	logic [`AMRW_LEN_W-1:0]  cnt_r;
	logic [`AMRW_DATA_W-1:0] rdata_r;
	logic                    rlast_r;
	logic                    bvalid_r;
	logic [`AMRW_ID_W-1:0]   bid_r;
	logic                    id_on;
	logic                    ar_hs;
	logic                    r_hs;
	logic                    b_hs;
	logic                    wr_take;

	assign id_on   = MEM_MODE & ID_EN;
	assign ar_hs   = S_AXI_ARVALID & S_AXI_ARREADY;
	assign r_hs    = S_AXI_RVALID & S_AXI_RREADY;
	assign b_hs    = S_AXI_BVALID & S_AXI_BREADY;
	assign wr_take = WR_DONE & WR_DONE_RDY;

	// command capture: register mode ignores size and type, forces full width incr
	always_comb begin
		cmd_nxt.id    = id_on ? S_AXI_ARID : '0;
		cmd_nxt.len   = S_AXI_ARLEN;
		cmd_nxt.size  = MEM_MODE ? S_AXI_ARSIZE : `AMRW_SIZE_FULL;
		cmd_nxt.burst = MEM_MODE ? S_AXI_ARBURST : `AMRW_BURST_INC;
	end

	// next state of the read engine, one memory access per beat
	always_comb begin
		case (state_r)
			amrw_pkg::ST_IDLE: begin
				state_nxt = ar_hs ? amrw_pkg::ST_FETCH : amrw_pkg::ST_IDLE;
			end
			amrw_pkg::ST_FETCH: begin
				state_nxt = amrw_pkg::ST_CAP;
			end
			amrw_pkg::ST_CAP: begin
				state_nxt = amrw_pkg::ST_BEAT;
			end
			amrw_pkg::ST_BEAT: begin
				if (r_hs) begin
					state_nxt = rlast_r ? amrw_pkg::ST_IDLE : amrw_pkg::ST_FETCH;
				end else begin
					state_nxt = amrw_pkg::ST_BEAT;
				end
			end
			default: begin
				state_nxt = amrw_pkg::ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r <= amrw_pkg::ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// command and beat counter; counter reloads on every accepted address
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cmd_r <= '0;
			cnt_r <= '0;
		end else if (ar_hs) begin
			cmd_r <= cmd_nxt;
			cnt_r <= S_AXI_ARLEN;
		end else if (r_hs && !rlast_r) begin
			cnt_r <= cnt_r - 8'h1;
		end
	end

	// beat address: only the start comes from the master
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			addr_r <= '0;
		end else if (ar_hs) begin
			addr_r <= S_AXI_ARADDR;
		end else if (r_hs && !rlast_r) begin
			addr_r <= next_addr(addr_r, cmd_r);
		end
	end

	// read data from the memory and last flag from the beat counter are captured together
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_r <= '0;
			rlast_r <= 1'b0;
		end else if (state_r == amrw_pkg::ST_CAP) begin
			rdata_r <= MEM_RDATA;
			rlast_r <= (cnt_r == 8'h0);
		end
	end

	// read channel outputs; valid only once data sits in the flop
	assign S_AXI_ARREADY = (state_r == amrw_pkg::ST_IDLE);
	assign S_AXI_RVALID  = (state_r == amrw_pkg::ST_BEAT);
	assign S_AXI_RDATA   = rdata_r;
	assign S_AXI_RLAST   = rlast_r & S_AXI_RVALID;
	assign S_AXI_RID     = id_on ? cmd_r.id : '0;
	assign S_AXI_RRESP   = `AMRW_RESP_OKAY;
	assign MEM_REN       = (state_r == amrw_pkg::ST_FETCH);
	assign MEM_ADDR      = addr_r;

	// ----------------------------------------------------------------
	// write response
	// ----------------------------------------------------------------

	// one response slot; a new completion may land in the cycle the old one leaves
	assign WR_DONE_RDY = !bvalid_r | S_AXI_BREADY;

	// pending flag: set wins over the master's acceptance
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bvalid_r <= 1'b0;
		end else if (wr_take) begin
			bvalid_r <= 1'b1;
		end else if (b_hs) begin
			bvalid_r <= 1'b0;
		end
	end

	// response ID, zero when IDs are off
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bid_r <= '0;
		end else if (wr_take) begin
			bid_r <= id_on ? WR_ID : '0;
		end
	end

	assign S_AXI_BVALID = bvalid_r;
	// switching IDs off must not leave a stale tag from an earlier write on the bus
	assign S_AXI_BID    = id_on ? bid_r : '0;
	// register mode has no code; the line then rests at zero
	assign S_AXI_BRESP  = id_on ? `AMRW_RESP_OKAY : 2'h0;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	// helper: beats handed over since the address, and the length asked for
	logic [`AMRW_LEN_W-1:0] hb_cnt_r;
	logic [`AMRW_LEN_W-1:0] hb_len_r;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hb_cnt_r <= '0;
			hb_len_r <= '0;
		end else if (ar_hs) begin
			hb_cnt_r <= '0;
			hb_len_r <= S_AXI_ARLEN;
		end else if (r_hs) begin
			hb_cnt_r <= hb_cnt_r + 8'h1;
		end
	end

	bresp_okay_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0)
		else $error("write response not OKAY");

	bresp_off_a: assert property (!id_on |-> S_AXI_BID == '0 && S_AXI_BRESP == 2'h0)
		else $error("response fields driven in register mode");

	bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BID))
		else $error("write response dropped before acceptance");

	bid_echo_a: assert property (wr_take && id_on |=>
		S_AXI_BVALID && S_AXI_BID == $past(WR_ID))
		else $error("write response ID mismatch");

	ar_block_a: assert property (ar_hs |=> !S_AXI_ARREADY [*3])
		else $error("address accepted while burst busy");

	rid_echo_a: assert property (ar_hs && id_on |-> ##3
		S_AXI_RVALID && S_AXI_RID == $past(S_AXI_ARID, 3))
		else $error("read ID or first beat timing wrong");

	rlast_count_a: assert property (S_AXI_RVALID |->
		S_AXI_RLAST == (hb_cnt_r == hb_len_r))
		else $error("last flag on wrong beat");

	rvalid_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RLAST))
		else $error("read beat changed before acceptance");

	incr_step_a: assert property (r_hs && !S_AXI_RLAST &&
		cmd_r.burst != `AMRW_BURST_WRP |=> MEM_REN &&
		MEM_ADDR == ($past(MEM_ADDR) & ~(beat_bytes(cmd_r.size) - 32'h1))
		+ beat_bytes(cmd_r.size))
		else $error("incrementing address step wrong");

	rresp_okay_a: assert property (S_AXI_RVALID |-> S_AXI_RRESP == 2'h0)
		else $error("read response not OKAY");

	// two empty cycles after each beat while the memory is read again
	beat_gap_a: assert property (r_hs |=> !S_AXI_RVALID [*2])
		else $error("read beat offered before memory data");

	last_idle_a: assert property (r_hs && S_AXI_RLAST |=> S_AXI_ARREADY)
		else $error("engine busy after final beat");

	bvalid_set_a: assert property (wr_take |=> S_AXI_BVALID)
		else $error("write completion gave no response");

	bvalid_clear_a: assert property (b_hs && !wr_take |=> !S_AXI_BVALID)
		else $error("write response repeated after acceptance");

	reg_incr_a: assert property (ar_hs && !MEM_MODE |=>
		cmd_r.burst == `AMRW_BURST_INC && cmd_r.size == `AMRW_SIZE_FULL)
		else $error("register mode burst not full width incrementing");

	// expected wrap step as offset modulo region, assumes an aligned start
	wrap_step_a: assert property (r_hs && !S_AXI_RLAST &&
		cmd_r.burst == `AMRW_BURST_WRP |=> MEM_REN &&
		MEM_ADDR == $past(MEM_ADDR) - ($past(MEM_ADDR) % wrap_region(cmd_r)) +
		(($past(MEM_ADDR) % wrap_region(cmd_r)) + beat_bytes(cmd_r.size)) %
		wrap_region(cmd_r))
		else $error("wrapping address step wrong");

	wrap_burst_c: cover property (ar_hs && MEM_MODE &&
		S_AXI_ARBURST == `AMRW_BURST_WRP && S_AXI_ARLEN == 8'h3);
	rready_stall_c: cover property (S_AXI_RVALID && !S_AXI_RREADY ##1 r_hs);
	bresp_b2b_c: cover property (b_hs && wr_take);
	long_burst_c: cover property (r_hs && S_AXI_RLAST && hb_len_r == 8'h7);

endmodule : amrw_slave
`default_nettype wire

// File: verification/amrw_mem_model.sv
// behavioural block memory standing behind the slave's memory port
`timescale 1ns/100ps
`default_nettype none

module amrw_mem_model (
	input  wire logic        CLK,      // bus clock
	input  wire logic        RESET_N,  // async reset, active low
	input  wire logic        MEM_REN,  // read strobe
	input  wire logic [31:0] MEM_ADDR, // byte address
	output logic      [31:0] MEM_RDATA // data one cycle after strobe
);
	// ----
	// read port
	// ----
	// data is a pattern of the address so a wrong beat address shows;
	// off the valid cycle the bus flips each cycle, so data taken an odd number of cycles late never passes
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N)
			MEM_RDATA <= 32'h0;
		else if (MEM_REN)
			MEM_RDATA <= MEM_ADDR ^ 32'h5a5a_0000;
		else
			MEM_RDATA <= ~MEM_RDATA;
	end
endmodule : amrw_mem_model

`default_nettype wire

// File: verification/axi4_slave_read_and_write_response_bench.sv
// self-checking bench for the read path and write response
`timescale 1ns/100ps
`default_nettype none

module axi4_slave_read_and_write_response_bench;
	// ----
	// signals and instances
	// ----
	logic        CLK, RESET_N, MEM_MODE, ID_EN, WR_DONE, WR_DONE_RDY, MEM_REN;
	logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RLAST, S_AXI_RVALID, S_AXI_RREADY;
	logic        S_AXI_BVALID, S_AXI_BREADY;
	logic [3:0]  S_AXI_ARID, S_AXI_RID, S_AXI_BID, WR_ID;
	logic [31:0] S_AXI_ARADDR, S_AXI_RDATA, MEM_ADDR, MEM_RDATA;
	logic [7:0]  S_AXI_ARLEN;
	logic [2:0]  S_AXI_ARSIZE;
	logic [1:0]  S_AXI_ARBURST, S_AXI_RRESP, S_AXI_BRESP;
	int          err_count = 0;
	int          checks = 0;

	amrw_slave     amrw_slave_i (
		.CLK, .RESET_N, .MEM_MODE, .ID_EN,
		.S_AXI_ARID, .S_AXI_ARADDR, .S_AXI_ARLEN, .S_AXI_ARSIZE, .S_AXI_ARBURST,
		.S_AXI_ARVALID, .S_AXI_ARREADY,
		.S_AXI_RID, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RLAST, .S_AXI_RVALID, .S_AXI_RREADY,
		.WR_DONE, .WR_ID, .WR_DONE_RDY,
		.S_AXI_BID, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.MEM_REN, .MEM_ADDR, .MEM_RDATA
	);
	amrw_mem_model amrw_mem_model_i (.CLK, .RESET_N, .MEM_REN, .MEM_ADDR, .MEM_RDATA);

	// 25 MHz bus clock
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	// ----
	// tasks
	// ----
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk

	task automatic summarize();
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	// one read burst; beat addresses are worked out here, data is their pattern
	task automatic rd(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len,
		input logic [2:0] sz, input logic [1:0] bt, input logic [3:0] eid, input int stall);
		logic [31:0] rg, base, es;
		int t;
		@(posedge CLK);
		S_AXI_ARID    <= id;
		S_AXI_ARADDR  <= a;
		S_AXI_ARLEN   <= len;
		S_AXI_ARSIZE  <= sz; // never wider than the data bus
		S_AXI_ARBURST <= bt;
		S_AXI_ARVALID <= 1'b1; // held with its fields until taken
		if (!MEM_MODE) begin
			sz = 3'h2; // register mode ignores size and type
			bt = 2'h1;
		end
		es = 32'h1 << sz;
		rg = es * (len + 1);
		base = a & ~(rg - 1);
		t = 0;
		do begin @(negedge CLK); t++; end while (!S_AXI_ARREADY && t < 50);
		@(posedge CLK);
		S_AXI_ARVALID <= 1'b0;
		for (int n = 0; n <= len; n++) begin
			t = 0;
			do begin @(negedge CLK); t++; end while (!S_AXI_RVALID && t < 50);
			repeat (stall) @(negedge CLK);
			chk(S_AXI_RVALID === 1'b1 && S_AXI_ARREADY === 1'b0, "beat");
			chk(S_AXI_RDATA === (a ^ 32'h5a5a_0000), "addr");
			chk(S_AXI_RID === eid && S_AXI_RRESP === 2'h0, "id");
			chk(S_AXI_RLAST === (n == len), "last");
			@(posedge CLK);
			S_AXI_RREADY <= 1'b1;
			@(posedge CLK);
			S_AXI_RREADY <= 1'b0;
			a = (bt == 2'h2) ? base | ((a + es) & (rg - 1)) : (a & ~(es - 1)) + es;
		end
		@(negedge CLK);
		chk(S_AXI_ARREADY === 1'b1 && S_AXI_RVALID === 1'b0, "idle");
	endtask : rd

	// one write completion, master stalls the response for a while
	task automatic wr(input logic [3:0] id, input logic [3:0] eid, input int stall);
		int t;
		@(posedge CLK);
		WR_DONE <= 1'b1;
		WR_ID   <= id;
		t = 0;
		do begin @(negedge CLK); t++; end while (!WR_DONE_RDY && t < 50);
		@(posedge CLK);
		WR_DONE <= 1'b0;
		@(negedge CLK);
		chk(S_AXI_BVALID === 1'b1 && S_AXI_BID === eid, "bid");
		chk(S_AXI_BRESP === 2'h0, "bresp");
		repeat (stall) @(negedge CLK);
		chk(S_AXI_BVALID === 1'b1 && WR_DONE_RDY === 1'b0, "held");
		@(posedge CLK);
		S_AXI_BREADY <= 1'b1;
		@(posedge CLK);
		S_AXI_BREADY <= 1'b0;
		@(negedge CLK);
		chk(S_AXI_BVALID === 1'b0, "bvalid");
	endtask : wr

	// ----
	// tests
	// ----
	initial begin
		{RESET_N, WR_DONE, S_AXI_ARVALID, S_AXI_RREADY, S_AXI_BREADY} = '0;
		{S_AXI_ARID, WR_ID, S_AXI_ARADDR, S_AXI_ARLEN, S_AXI_ARSIZE, S_AXI_ARBURST} = '0;
		MEM_MODE = 1'b1;
		ID_EN    = 1'b1;
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		@(negedge CLK);
		chk(S_AXI_ARREADY === 1'b1 && S_AXI_RVALID === 1'b0, "rst rd");
		chk(S_AXI_BVALID === 1'b0 && WR_DONE_RDY === 1'b1, "rst wr");
		rd(4'h5, 32'h100, 8'h03, 3'h2, 2'h1, 4'h5, 0);
		rd(4'h9, 32'h108, 8'h03, 3'h2, 2'h2, 4'h9, 2);
		rd(4'h3, 32'h202, 8'h02, 3'h1, 2'h1, 4'h3, 0);
		rd(4'hf, 32'h30, 8'h00, 3'h2, 2'h1, 4'hf, 0);
		rd(4'h6, 32'h1f0, 8'h07, 3'h2, 2'h1, 4'h6, 1);
		rd(4'h8, 32'h301, 8'h01, 3'h2, 2'h1, 4'h8, 0);
		rd(4'h4, 32'h10, 8'h01, 3'h2, 2'h3, 4'h4, 0);
		wr(4'ha, 4'ha, 3);
		wr(4'h1, 4'h1, 0);
		@(posedge CLK);
		ID_EN <= 1'b0;
		@(negedge CLK);
		chk(S_AXI_BID === 4'h0 && S_AXI_RID === 4'h0, "ids off");
		rd(4'h7, 32'h44, 8'h01, 3'h2, 2'h2, 4'h0, 0);
		wr(4'h7, 4'h0, 1);
		@(posedge CLK);
		MEM_MODE <= 1'b0;
		rd(4'h2, 32'h208, 8'h03, 3'h1, 2'h2, 4'h0, 1);
		wr(4'h2, 4'h0, 0);
		summarize();
	end

	// watchdog, well beyond the few hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge CLK);
		err_count++;
		summarize();
	end
endmodule : axi4_slave_read_and_write_response_bench

`default_nettype wire
